// ==== rtl/mdl_map.vh ====
// register map, field positions, reset values and timing counts of the margin DAC limiter
// assumes a 100 MHz core clock and word-aligned AHB-Lite byte addresses
`ifndef MDL_MAP_VH
`define MDL_MAP_VH

// ------------------------------------------------------------
// channel registers: base = channel * stride
// ------------------------------------------------------------
`define MDL_NUM_CH        4
`define MDL_CH_STRIDE     8'h10
`define MDL_OFF_CODE      4'h0
`define MDL_OFF_UPPER     4'h4
`define MDL_OFF_LOWER     4'h8
`define MDL_OFF_CTRL      4'hC
`define MDL_OFF_STATUS    8'h40

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define MDL_CTRL_EN_BIT   0
`define MDL_CTRL_RNG_LO   4
`define MDL_ST_DONE_BIT   0
`define MDL_ST_DRV_LO     4
`define MDL_ST_INV_LO     8
`define MDL_ST_TRK_LO     12

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MDL_RST_CODE      8'h7F
`define MDL_RST_UPPER     8'h00
`define MDL_RST_LOWER     8'hFF
`define MDL_RST_RANGE     2'h0
`define MDL_MIDCODE       8'h7F

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MDL_CLK_MHZ       100
`define MDL_TRACK_NS      1000
`define MDL_TRACK_CYC     ((`MDL_TRACK_NS * `MDL_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/mdl_limiter.v ====
// margin DAC limiter: four code channels with clipping, buffer enable sequence,
// start-up limit load and an AHB-Lite register slave.
// assumes nvm port on the same clock; analog DAC and buffer sit outside.
//
// How it works
// - four independent channels, each driving own pin
// - each channel holds unsigned 8-bit code
// - two-bit range selects one of four midcode offsets
// - code span +128/-127 around midcode 0x7F
// - applied code clipped between lower and upper limits
// - lower above upper keeps buffer high-impedance
// - limits loaded from nonvolatile store at start-up
// - buffer tracks pin first, then drives DAC
// - host writes code; new value applied to output
// - bus stalled until start-up download completes
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "mdl_map.vh"

module mdl_limiter (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rstn_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // nonvolatile limit store
  output reg         nvm_rd_o,
  output reg  [2:0]  nvm_addr_o,
  input  wire        nvm_ack_i,
  input  wire [7:0]  nvm_rdata_i,
  // margin outputs, channel n in slice n
  output reg  [31:0] margin_code_o,
  output reg  [7:0]  margin_range_o,
  output reg  [3:0]  buf_track_o,
  output reg  [3:0]  buf_src_dac_o,
  output reg  [3:0]  buf_drive_o
);

  // ------------------------------------------------------------
  // constants and state
  // ------------------------------------------------------------
  localparam [1:0] ST_LOAD_REQ  = 2'h0;
  localparam [1:0] ST_LOAD_WAIT = 2'h1;
  localparam [1:0] ST_RUN       = 2'h2;

  localparam [1:0] CH_OFF   = 2'h0;
  localparam [1:0] CH_TRACK = 2'h1;
  localparam [1:0] CH_DRIVE = 2'h2;

  // the count fits eight bits; cut on purpose to the counter width
  localparam integer TRACK_CYC_N = `MDL_TRACK_CYC;
  localparam [7:0]   TRACK_CYC   = TRACK_CYC_N[7:0];

  reg [1:0]  load_state;
  reg        load_done;
  reg [7:0]  code_reg   [0:3];
  reg [7:0]  upper_lim  [0:3];
  reg [7:0]  lower_lim  [0:3];
  reg        chan_en    [0:3];
  reg [1:0]  chan_range [0:3];
  reg [1:0]  chan_state [0:3];
  reg [7:0]  chan_cnt   [0:3];

  reg        wr_pend;
  reg        rd_pend;
  reg [7:0]  acc_addr;

  integer    i;
  // one loop index per process so each keeps a single driver
  integer    j;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // clip a code into [lo, hi]; caller handles lo > hi
  function [7:0] clip_code;
    input [7:0] code;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (code < lo) begin
        clip_code = lo;
      end else if (code > hi) begin
        clip_code = hi;
      end else begin
        clip_code = code;
      end
    end
  endfunction

  // limits crossed: channel must stay three-stated
  function limits_bad;
    input [7:0] lo;
    input [7:0] hi;
    begin
      limits_bad = (lo > hi);
    end
  endfunction

  // status word built from live channel state
  function [31:0] status_word;
    input dummy;
    integer k;
    begin
      status_word = 32'h0000_0000;
      status_word[`MDL_ST_DONE_BIT] = load_done;
      for (k = 0; k < `MDL_NUM_CH; k = k + 1) begin
        status_word[`MDL_ST_DRV_LO + k] = (chan_state[k] == CH_DRIVE);
        status_word[`MDL_ST_INV_LO + k] = limits_bad(lower_lim[k], upper_lim[k]);
        status_word[`MDL_ST_TRK_LO + k] = (chan_state[k] == CH_TRACK);
      end
    end
  endfunction

  // register readback; unmapped addresses read zero
  function [31:0] read_word;
    input [7:0] addr;
    reg   [1:0] ch;
    begin
      ch = addr[5:4];
      read_word = 32'h0000_0000;
      if (addr == `MDL_OFF_STATUS) begin
        read_word = status_word(1'b0);
      end else if (addr[7:6] == 2'h0) begin
        case (addr[3:0])
          `MDL_OFF_CODE:  read_word[7:0] = code_reg[ch];
          `MDL_OFF_UPPER: read_word[7:0] = upper_lim[ch];
          `MDL_OFF_LOWER: read_word[7:0] = lower_lim[ch];
          `MDL_OFF_CTRL: begin
            read_word[`MDL_CTRL_EN_BIT] = chan_en[ch];
            read_word[`MDL_CTRL_RNG_LO +: 2] = chan_range[ch];
          end
          default: read_word = 32'h0000_0000;
        endcase
      end
    end
  endfunction

  // ------------------------------------------------------------
  // start-up limit download
  // ------------------------------------------------------------
  // even nvm address = lower limit, odd = upper limit of channel addr/2
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_state <= ST_LOAD_REQ;
      load_done  <= 1'b0;
      nvm_rd_o   <= 1'b0;
      nvm_addr_o <= 3'h0;
    end else begin
      case (load_state)
        ST_LOAD_REQ: begin
          nvm_rd_o   <= 1'b1;
          load_state <= ST_LOAD_WAIT;
        end
        ST_LOAD_WAIT: begin
          if (nvm_ack_i) begin
            nvm_rd_o <= 1'b0;
            if (nvm_addr_o == 3'h7) begin
              load_state <= ST_RUN;
              load_done  <= 1'b1;
            end else begin
              nvm_addr_o <= nvm_addr_o + 3'h1;
              load_state <= ST_LOAD_REQ;
            end
          end
        end
        ST_RUN: begin
          nvm_rd_o <= 1'b0;
        end
        default: begin
          load_state <= ST_LOAD_REQ;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave and register file
  // ------------------------------------------------------------
  // reads take one wait state so a read right after a write sees the new value
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hreadyout_o <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
      hresp_o     <= 1'b0;
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      acc_addr    <= 8'h00;
      for (j = 0; j < `MDL_NUM_CH; j = j + 1) begin
        code_reg[j]   <= `MDL_RST_CODE;
        upper_lim[j]  <= `MDL_RST_UPPER;
        lower_lim[j]  <= `MDL_RST_LOWER;
        chan_en[j]    <= 1'b0;
        chan_range[j] <= `MDL_RST_RANGE;
      end
    end else begin
      hresp_o <= 1'b0;
      if (load_state == ST_LOAD_WAIT && nvm_ack_i) begin
        if (nvm_addr_o[0]) begin
          upper_lim[nvm_addr_o[2:1]] <= nvm_rdata_i;
        end else begin
          lower_lim[nvm_addr_o[2:1]] <= nvm_rdata_i;
        end
      end
      if (!load_done) begin
        hreadyout_o <= (load_state == ST_RUN);
      end else if (rd_pend) begin
        hrdata_o    <= read_word(acc_addr);
        hreadyout_o <= 1'b1;
        rd_pend     <= 1'b0;
      end else begin
        hreadyout_o <= 1'b1;
        if (wr_pend && acc_addr[7:6] == 2'h0) begin
          case (acc_addr[3:0])
            `MDL_OFF_CODE:  code_reg[acc_addr[5:4]]  <= hwdata_i[7:0];
            `MDL_OFF_UPPER: upper_lim[acc_addr[5:4]] <= hwdata_i[7:0];
            `MDL_OFF_LOWER: lower_lim[acc_addr[5:4]] <= hwdata_i[7:0];
            `MDL_OFF_CTRL: begin
              chan_en[acc_addr[5:4]]    <= hwdata_i[`MDL_CTRL_EN_BIT];
              chan_range[acc_addr[5:4]] <= hwdata_i[`MDL_CTRL_RNG_LO +: 2];
            end
            default: acc_addr <= acc_addr;
          endcase
        end
        wr_pend <= 1'b0;
        if (hsel_i && htrans_i[1] && hready_i) begin
          acc_addr <= haddr_i[7:0];
          if (hwrite_i) begin
            wr_pend <= 1'b1;
          end else begin
            rd_pend     <= 1'b1;
            hreadyout_o <= 1'b0;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // per-channel code clipping and buffer enable sequence
  // ------------------------------------------------------------
  // the analog offset per range is outside; code span about 0x7F is fixed
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      margin_code_o  <= {4{`MDL_MIDCODE}};
      margin_range_o <= 8'h00;
      buf_track_o    <= 4'h0;
      buf_src_dac_o  <= 4'h0;
      buf_drive_o    <= 4'h0;
      for (i = 0; i < `MDL_NUM_CH; i = i + 1) begin
        chan_state[i] <= CH_OFF;
        chan_cnt[i]   <= 8'h00;
      end
    end else begin
      for (i = 0; i < `MDL_NUM_CH; i = i + 1) begin
        margin_code_o[i*8 +: 8] <=
          clip_code(code_reg[i], lower_lim[i], upper_lim[i]);
        margin_range_o[i*2 +: 2] <= chan_range[i];
        if (!chan_en[i] || !load_done || limits_bad(lower_lim[i], upper_lim[i])) begin
          chan_state[i]    <= CH_OFF;
          chan_cnt[i]      <= 8'h00;
          buf_track_o[i]   <= 1'b0;
          buf_src_dac_o[i] <= 1'b0;
          buf_drive_o[i]   <= 1'b0;
        end else begin
          case (chan_state[i])
            CH_OFF: begin
              chan_state[i]  <= CH_TRACK;
              chan_cnt[i]    <= 8'h00;
              buf_track_o[i] <= 1'b1;
            end
            CH_TRACK: begin
              // buffer follows the pin, output stage stays off
              if (chan_cnt[i] == TRACK_CYC - 8'h01) begin
                chan_state[i]    <= CH_DRIVE;
                buf_track_o[i]   <= 1'b0;
                buf_src_dac_o[i] <= 1'b1;
                buf_drive_o[i]   <= 1'b1;
              end else begin
                chan_cnt[i] <= chan_cnt[i] + 8'h01;
              end
            end
            CH_DRIVE: begin
              buf_src_dac_o[i] <= 1'b1;
              buf_drive_o[i]   <= 1'b1;
            end
            default: begin
              chan_state[i] <= CH_OFF;
            end
          endcase
        end
      end
    end
  end

endmodule // mdl_limiter

// ==== tb/mdl_limiter_sva.sv ====
// port checker for the margin limiter: bus timing, limit load, buffer sequence
// assumes hready_i is fed back from hreadyout_o (single slave)
`timescale 1ns/100ps
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module mdl_limiter_sva (
  // clock and reset
  input wire        core_clk_i,
  input wire        rstn_i,
  // bus
  input wire        hsel_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire        hreadyout_o,
  // limit store
  input wire        nvm_rd_o,
  input wire [2:0]  nvm_addr_o,
  input wire        nvm_ack_i,
  // buffers
  input wire [3:0]  buf_track_o,
  input wire [3:0]  buf_src_dac_o,
  input wire [3:0]  buf_drive_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire taken = hsel_i & htrans_i[1] & hready_i & hreadyout_o;
  sequence s_track; buf_track_o[0] [*8]; endsequence
  sequence s_reissue; !nvm_rd_o ##1 nvm_rd_o; endsequence
  AST_NO_ACK_LOAD:
  assert property (nvm_rd_o |-> !hreadyout_o) else $error("bus answered during load");
  AST_NVM_HOLD:
  assert property (nvm_rd_o && !nvm_ack_i |=> nvm_rd_o && $stable(nvm_addr_o))
    else $error("store request dropped early");
  AST_NVM_NEXT:
  assert property (nvm_rd_o && nvm_ack_i && nvm_addr_o != 3'h7 |=>
    s_reissue ##0 nvm_addr_o == $past(nvm_addr_o, 2) + 3'h1) else $error("store order bad");
  AST_SRC_DRV:
  assert property (buf_src_dac_o == buf_drive_o) else $error("source and drive differ");
  AST_TRACK_HOLD:
  assert property ($rose(buf_track_o[0]) |-> s_track) else $error("tracking too short");
  AST_NO_OVERLAP:
  assert property (!(|(buf_track_o & buf_drive_o))) else $error("drive while tracking");
  AST_DRV_AFTER:
  assert property ($rose(buf_drive_o[0]) |-> $past(buf_track_o[0])) else $error("drive skipped");
  AST_RD_WAIT:
  assert property (taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait");
  AST_WR_FAST:
  assert property (taken && hwrite_i |=> hreadyout_o) else $error("write stalled");
endmodule // mdl_limiter_sva
bind mdl_limiter mdl_limiter_sva u_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o),
  .nvm_ack_i(nvm_ack_i), .buf_track_o(buf_track_o), .buf_src_dac_o(buf_src_dac_o),
  .buf_drive_o(buf_drive_o));

// ==== tb/mdl_nvm_model.sv ====
// nonvolatile limit store model: one byte per request, prompt or slow
// assumes requests are held until acknowledged, same clock as the limiter
`timescale 1ns/100ps
// ------------------------------------------------------------
// store
// ------------------------------------------------------------
module mdl_nvm_model (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rstn_i,
  // request side
  input  wire        slow_i,
  input  wire [63:0] lim_i,
  input  wire        rd_i,
  input  wire [2:0]  addr_i,
  output logic       ack_o,
  output logic [7:0] rdata_o
);
  logic [1:0] wait_cnt;
  // data line toggles outside acks so stale bytes never look valid
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o    <= 1'b0;
      rdata_o  <= 8'h00;
      wait_cnt <= 2'h0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (rd_i && !ack_o) begin
        if (!slow_i || wait_cnt == 2'h3) begin
          ack_o    <= 1'b1;
          rdata_o  <= lim_i[addr_i*8 +: 8];
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // mdl_nvm_model

// ==== tb/margin_dac_code_limiter_test.sv ====
// self-checking bench for the margin limiter over its bus, store and buffer pins
// assumes the store model above and a single-slave bus
`timescale 1ns/100ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module margin_dac_code_limiter_test;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        hsel_i     = 1'b0;
  logic        hwrite_i   = 1'b0;
  logic        slow       = 1'b0;
  logic [1:0]  htrans_i   = 2'h0;
  logic [31:0] haddr_i    = 32'h0;
  logic [31:0] hwdata_i   = 32'h0;
  wire  [31:0] hrdata_o, margin_code_o;
  wire         hreadyout_o, hresp_o, nvm_rd_o, nvm_ack_i;
  wire  [2:0]  nvm_addr_o;
  wire  [7:0]  nvm_rdata_i, margin_range_o;
  wire  [3:0]  buf_track_o, buf_src_dac_o, buf_drive_o;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          n;
  logic [31:0] rd;
  // address, written code, expected applied code
  logic [23:0] rows [9] = '{24'h001020, 24'h00F0E0, 24'h002020, 24'h00E0E0, 24'h005555,
                            24'h10FFFF, 24'h100000, 24'h307F10, 24'h300510};
  always #5 core_clk_i = ~core_clk_i;
  mdl_limiter dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .nvm_rd_o(nvm_rd_o),
    .nvm_addr_o(nvm_addr_o), .nvm_ack_i(nvm_ack_i), .nvm_rdata_i(nvm_rdata_i),
    .margin_code_o(margin_code_o), .margin_range_o(margin_range_o),
    .buf_track_o(buf_track_o), .buf_src_dac_o(buf_src_dac_o), .buf_drive_o(buf_drive_o));
  // ch0 20..E0, ch1 full span, ch2 inverted, ch3 pinned at 10
  mdl_nvm_model u_nvm (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .lim_i(64'h1010_4080_FF00_E020), .rd_i(nvm_rd_o), .addr_i(nvm_addr_o),
    .ack_o(nvm_ack_i), .rdata_o(nvm_rdata_i));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // single transfer; held until hready is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    results;
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    bus(0, 8'h40, 0, rd); chk(rd, 32'h0000_0401);
    bus(0, 8'h04, 0, rd); chk(rd, 32'hE0);
    bus(0, 8'h28, 0, rd); chk(rd, 32'h80);
    $display("test load done");
    foreach (rows[k]) begin
      bus(1, rows[k][23:16], {24'h0, rows[k][15:8]}, rd);
      bus(0, rows[k][23:16], 0, rd); chk(rd, {24'h0, rows[k][15:8]});
      chk(margin_code_o[rows[k][21:20]*8 +: 8], rows[k][7:0]);
      chk(hresp_o, 1'b0);
    end
    $display("test clip table done");
    for (n = 0; n < 4; n++) begin
      bus(1, 8'h1C, {26'h0, n[1:0], 4'h0}, rd);
      repeat (2) @(posedge core_clk_i); chk(margin_range_o[3:2], n[1:0]);
    end
    $display("test ranges done");
    // host order: outputs off, code at feedback level, then enable
    bus(1, 8'h0C, 32'h0, rd);
    bus(1, 8'h00, 32'h7F, rd);
    bus(1, 8'h2C, 32'h1, rd);
    bus(1, 8'h0C, 32'h1, rd);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (n == 2) chk(buf_track_o, 4'b0001);
    end while (buf_drive_o[0] !== 1'b1 && n < 300);
    chk(n, 102);
    chk(buf_src_dac_o, 4'b0001);
    chk(margin_code_o[7:0], 8'h7F);
    bus(0, 8'h40, 0, rd); chk(rd, 32'h0000_0411);
    bus(1, 8'h0C, 32'h0, rd);
    repeat (2) @(posedge core_clk_i); chk(buf_drive_o, 4'h0);
    $display("test enable sequence done");
    bus(1, 8'h80, 32'h5A, rd);
    bus(0, 8'h80, 0, rd); chk(rd, 32'h0);
    $display("test unmapped done");
    slow   <= 1'b1;
    rstn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    bus(0, 8'h40, 0, rd); chk(rd, 32'h0000_0401);
    chk(margin_code_o[31:24], 8'h10);
    $display("test slow reload done");
    results;
  end
endmodule // margin_dac_code_limiter_test
